//--- psfm_pkg.sv
// shared types and constants of the power stage fault manager
package psfm_pkg;

  // event counting: fault at ten events, three good cycles clear the count
  localparam int unsigned FAULT_EVENT_LIMIT = 10;
  localparam int unsigned GOOD_RUN_CLEAR    = 3;
  localparam int unsigned CNT_W             = 4;

  // comparator figures kept for reference, sensing itself is analog
  localparam int unsigned OC_LIMIT_AMPS     = 100;
  localparam int unsigned OTP_RISE_DEGC     = 140;
  localparam int unsigned OTP_FALL_DEGC     = 128;

  // current report drive code
  typedef enum logic [3:0] {
    REP_SENSE = 4'h1,  // real sensed current
    REP_REF   = 4'h2,  // shorted to reference
    REP_ZERO  = 4'h4,  // pulled to 0 V
    REP_HIGH  = 4'h8   // pulled to high level
  } psfm_rep_e;

  // fault/temperature pin drive code
  typedef enum logic [2:0] {
    TF_TEMP = 3'h1,    // analog temperature report
    TF_HIGH = 3'h2,    // catastrophic, pulled high
    TF_WEAK = 3'h4     // weak pull down
  } psfm_tf_e;

  // top-level supervisor state
  typedef enum logic [2:0] {
    ST_LOCK = 3'h1,    // driver supply low before first start
    ST_RUN  = 3'h2,    // normal operation
    ST_DROP = 3'h4     // supply lost after normal operation
  } psfm_st_e;

  // sense inputs, sampled every clock; bootstrap under-voltage and over-current are counted at each switching cycle start
  typedef struct packed {
    logic oc;          // current above limit
    logic boot_uv;     // bootstrap under-voltage
    logic hs_short;    // high-side short
    logic otp_hi;      // above rising temperature threshold
    logic otp_lo;      // below falling temperature threshold
    logic supply_ok;   // driver supply above lockout
  } psfm_sense_s;

  // event counter state
  typedef struct packed {
    logic [CNT_W-1:0] events;
    logic [CNT_W-1:0] good;
    logic             fault;
  } psfm_cnt_s;

endpackage : psfm_pkg

//--- psfm_event_counter.sv
// event counter: fault after ten events without three good cycles between
`timescale 1ns/10ps
`default_nettype none
module psfm_event_counter
  import psfm_pkg::*;
#(
  parameter int unsigned LIMIT    = FAULT_EVENT_LIMIT,
  parameter int unsigned GOOD_RUN = GOOD_RUN_CLEAR
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic cycle_tick,
  input  wire logic event_hit,
  output logic      fault
);

  psfm_cnt_s s_r;
  psfm_cnt_s s_nxt;

  localparam logic [CNT_W-1:0] LIMIT_C = CNT_W'(LIMIT);
  localparam logic [CNT_W-1:0] GOOD_C  = CNT_W'(GOOD_RUN);

  // count once per switching cycle; fault is sticky until reset
  always_comb begin
    s_nxt = s_r;
    if (cycle_tick && !s_r.fault) begin
      if (event_hit) begin
        s_nxt.good   = '0;
        s_nxt.events = s_r.events + 4'h1;
        if (s_r.events + 4'h1 >= LIMIT_C) begin
          s_nxt.fault = 1'b1;
        end
      end else begin
        s_nxt.good = s_r.good + 4'h1;
        if (s_r.good + 4'h1 >= GOOD_C) begin
          s_nxt.events = '0;
          s_nxt.good   = '0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fault = s_r.fault;

endmodule : psfm_event_counter
`default_nettype wire

//--- psfm_fault_manager.sv
// fault supervision of a synchronous buck power stage
// Contract
// - compare high-side current every switching cycle
// - over-current truncates on-pulse, keep following PWM
// - ten over-current cycles raise fault, report current
// - fault at ten events, three good clear
// - bootstrap under-voltage before and during operation
// - bootstrap fault: fault high, report 0V latched
// - supply lockout: weak pulls, no switching, report=reference
// - over-temperature: fault high, report reference, hysteresis
// - supply loss after run: stop, both zero
`timescale 1ns/10ps
`default_nettype none
module psfm_fault_manager
  import psfm_pkg::*;
#(
  parameter int unsigned LIMIT    = FAULT_EVENT_LIMIT,
  parameter int unsigned GOOD_RUN = GOOD_RUN_CLEAR
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        pwm_in,
  input  wire psfm_sense_s sense,
  output logic             hs_gate,
  output logic             ls_gate,
  output logic             pwm_pull_down,
  output psfm_tf_e         temp_fault_out,
  output psfm_rep_e        current_report_out
);

  typedef struct packed {
    psfm_st_e  st;
    logic      pwm_d;
    logic      trunc;
    logic      oc_cycle;
    logic      otp;
    logic      hss_lat;
    logic      hs;
    logic      ls;
    logic      pd;
    psfm_tf_e  tf;
    psfm_rep_e rep;
  } psfm_state_s;

  // pin codes of one fault class, fault pin and current report together
  typedef struct packed {
    psfm_tf_e  tf;
    psfm_rep_e rep;
  } psfm_pins_s;

  // gate drive and pwm pull request of one clock
  typedef struct packed {
    logic hs;
    logic ls;
    logic pd;
  } psfm_gates_s;

  psfm_state_s s_r;
  psfm_state_s s_nxt;
  logic        cycle_tick;
  logic        oc_fault;
  logic        boot_fault;
  psfm_gates_s gates_nxt;
  psfm_pins_s  pins_nxt;

  // gates follow pwm only in run; a cut pulse keeps the high side off
  // until the next cycle start, while the low side keeps following pwm
  function automatic psfm_gates_s drive_gates(
    input psfm_st_e st,
    input logic     pwm,
    input logic     cut
  );
    psfm_gates_s g;
    g = '0;
    if (st == ST_RUN) begin
      g.hs = pwm && !cut;
      g.ls = !pwm;
    end else begin
      // weak pull on the pwm line in either supply-low state; the
      // controller may still drive the line, so this is only a request
      g.pd = 1'b1;
    end
    return g;
  endfunction : drive_gates

  // fault class to pin codes, most severe first; the fault line is
  // wired between phases, so only the per-phase report names the class
  // and the faulty phase; a supply-low state outranks every latch
  function automatic psfm_pins_s encode_pins(
    input psfm_st_e st,
    input logic     short_lat,
    input logic     boot_lat,
    input logic     hot,
    input logic     oc_lat
  );
    psfm_pins_s p;
    p.tf  = TF_TEMP;
    p.rep = REP_SENSE;
    if (st == ST_LOCK) begin
      // not yet started: report tied to its reference
      p.tf  = TF_WEAK;
      p.rep = REP_REF;
    end else if (st == ST_DROP) begin
      // supply lost after start: report pulled to zero
      p.tf  = TF_WEAK;
      p.rep = REP_ZERO;
    end else if (short_lat) begin
      p.tf  = TF_HIGH;
      p.rep = REP_HIGH;
    end else if (boot_lat) begin
      p.tf  = TF_HIGH;
      p.rep = REP_ZERO;
    end else if (hot) begin
      p.tf  = TF_HIGH;
      p.rep = REP_REF;
    end else if (oc_lat) begin
      // report keeps the real current so the phase can be found
      p.tf  = TF_HIGH;
      p.rep = REP_SENSE;
    end
    return p;
  endfunction : encode_pins

  // a switching cycle starts at each rising pwm edge
  assign cycle_tick = pwm_in && !s_r.pwm_d;

  // over-current cycles, counted at each cycle start
  psfm_event_counter #(
    .LIMIT    (LIMIT),
    .GOOD_RUN (GOOD_RUN)
  ) u_oc_cnt (
    .clk        (clk),
    .nrst       (nrst),
    .cycle_tick (cycle_tick),
    .event_hit  (s_r.oc_cycle | (pwm_in & sense.oc)),
    .fault      (oc_fault)
  );

  // bootstrap under-voltage, sampled at each cycle start; a missing
  // capacitor shows at the very first cycle, so power-up is covered too
  psfm_event_counter #(
    .LIMIT    (LIMIT),
    .GOOD_RUN (GOOD_RUN)
  ) u_boot_cnt (
    .clk        (clk),
    .nrst       (nrst),
    .cycle_tick (cycle_tick),
    .event_hit  (sense.boot_uv),
    .fault      (boot_fault)
  );

  // supervisor, gate control and pin encoding
  always_comb begin
    s_nxt       = s_r;
    s_nxt.pwm_d = pwm_in;

    // over-current seen in this cycle; reset at the next cycle start
    if (cycle_tick) begin
      s_nxt.oc_cycle = 1'b0;
      s_nxt.trunc    = 1'b0;
    end
    if (pwm_in && sense.oc) begin
      s_nxt.oc_cycle = 1'b1;
      s_nxt.trunc    = 1'b1;
    end

    // temperature hysteresis
    if (sense.otp_hi) begin
      s_nxt.otp = 1'b1;
    end else if (sense.otp_lo) begin
      s_nxt.otp = 1'b0;
    end

    // first short event latches; no clear path short of reset
    if (sense.hs_short) begin
      s_nxt.hss_lat = 1'b1;
    end

    // supply state
    case (s_r.st)
      ST_LOCK: if (sense.supply_ok) s_nxt.st = ST_RUN;
      ST_RUN:  if (!sense.supply_ok) s_nxt.st = ST_DROP;
      ST_DROP: if (sense.supply_ok) s_nxt.st = ST_RUN;
      default: s_nxt.st = ST_LOCK;
    endcase

    // gates: follow pwm; truncation holds high side off till next cycle
    gates_nxt = drive_gates(s_nxt.st, pwm_in, s_nxt.trunc);
    s_nxt.hs  = gates_nxt.hs;
    s_nxt.ls  = gates_nxt.ls;
    s_nxt.pd  = gates_nxt.pd;

    // pin encoding, most severe first; short and bootstrap latches outrank temperature, which outranks the over-current latch
    pins_nxt  = encode_pins(s_nxt.st, s_nxt.hss_lat, boot_fault, s_nxt.otp, oc_fault);
    s_nxt.tf  = pins_nxt.tf;
    s_nxt.rep = pins_nxt.rep;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r.st       <= ST_LOCK;
      s_r.pwm_d    <= 1'b0;
      s_r.trunc    <= 1'b0;
      s_r.oc_cycle <= 1'b0;
      s_r.otp      <= 1'b0;
      s_r.hss_lat  <= 1'b0;
      s_r.hs       <= 1'b0;
      s_r.ls       <= 1'b0;
      s_r.pd       <= 1'b1;
      s_r.tf       <= TF_WEAK;
      s_r.rep      <= REP_REF;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hs_gate            = s_r.hs;
  assign ls_gate            = s_r.ls;
  assign pwm_pull_down      = s_r.pd;
  assign temp_fault_out     = s_r.tf;
  assign current_report_out = s_r.rep;

endmodule : psfm_fault_manager
`default_nettype wire

//--- psfm_fault_manager_asserts.sv
// port checker of the fault manager
`timescale 1ns/10ps
`default_nettype none
module psfm_fault_manager_asserts
  import psfm_pkg::*;
#(
  parameter int unsigned LIMIT    = FAULT_EVENT_LIMIT,
  parameter int unsigned GOOD_RUN = GOOD_RUN_CLEAR
) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        pwm_in,
  input wire psfm_sense_s sense,
  input wire logic        hs_gate,
  input wire logic        ls_gate,
  input wire logic        pwm_pull_down,
  input wire psfm_tf_e    temp_fault_out,
  input wire psfm_rep_e   current_report_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // gate only echoes the command, truncation may only shorten it
  property p_gate; hs_gate |-> $past(pwm_in); endproperty
  a_gate: assert property (p_gate) else $error("gate without pwm");
  property p_trunc; hs_gate && sense.oc |=> !hs_gate; endproperty
  a_trunc: assert property (p_trunc) else $error("pulse not cut");
  // supply low: no switching, weak pull on the fault pin
  property p_uvgate; !sense.supply_ok |=> !hs_gate && !ls_gate; endproperty
  a_uvgate: assert property (p_uvgate) else $error("switching in lockout");
  property p_uvtf; !sense.supply_ok |=> temp_fault_out == TF_WEAK; endproperty
  a_uvtf: assert property (p_uvtf) else $error("fault pin not weak");
  property p_uvpull; !sense.supply_ok |=> pwm_pull_down; endproperty
  a_uvpull: assert property (p_uvpull) else $error("pwm line not pulled");
  property p_drop; $fell(sense.supply_ok) && !pwm_pull_down
    |=> current_report_out == REP_ZERO; endproperty
  a_drop: assert property (p_drop) else $error("report not zero");
  // latched catastrophic reports, short outranks bootstrap
  property p_short; sense.hs_short && sense.supply_ok && !pwm_pull_down
    |-> ##[1:2] current_report_out == REP_HIGH; endproperty
  a_short: assert property (p_short) else $error("short not reported");
  property p_latch; current_report_out == REP_HIGH && sense.supply_ok
    |=> current_report_out == REP_HIGH; endproperty
  a_latch: assert property (p_latch) else $error("short not latched");
  property p_boot; current_report_out == REP_ZERO && temp_fault_out == TF_HIGH
    && sense.supply_ok && !sense.hs_short |=> current_report_out == REP_ZERO; endproperty
  a_boot: assert property (p_boot) else $error("boot not latched");
endmodule : psfm_fault_manager_asserts
bind psfm_fault_manager psfm_fault_manager_asserts #(.LIMIT(LIMIT), .GOOD_RUN(GOOD_RUN)) u_chk (
  .clk(clk), .nrst(nrst), .pwm_in(pwm_in), .sense(sense), .hs_gate(hs_gate),
  .ls_gate(ls_gate), .pwm_pull_down(pwm_pull_down), .temp_fault_out(temp_fault_out),
  .current_report_out(current_report_out));
`default_nettype wire

//--- psfm_ctrl_model.sv
// pwm controller model driving the command line
`timescale 1ns/10ps
`default_nettype none
module psfm_ctrl_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [3:0] period,
  output logic            pwm_in
);
  logic [3:0] cnt_r;
  // period picks prompt or slow cycles, two clocks high for any period from 2 up
  always_ff @(posedge clk) begin
    if (!nrst) cnt_r <= 4'h0;
    else cnt_r <= (cnt_r >= period) ? 4'h0 : cnt_r + 4'h1;
  end
  assign pwm_in = (cnt_r < 4'h2);  // keeps driving in lockout
endmodule : psfm_ctrl_model
`default_nettype wire

//--- psfm_fault_manager_tb.sv
// bench of the fault manager with a pwm controller model
`timescale 1ns/10ps
`default_nettype none
module psfm_fault_manager_tb
  import psfm_pkg::*;
;
  logic        clk;
  logic        nrst            = 1'b0;
  logic [3:0]  period          = 4'h3;
  logic        pwm_in;
  logic        hs_gate;
  logic        ls_gate;
  logic        pull_down;
  psfm_sense_s sense           = '0;
  psfm_tf_e    tf;
  psfm_rep_e   rep;
  logic [31:0] lfsr            = 32'hFDA8;
  int          n_errors        = 0;
  int          samples_checked = 0;
  int          cycles          = 0;
  // free clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  psfm_ctrl_model psfm_ctrl_model_inst (.clk(clk), .nrst(nrst), .period(period), .pwm_in(pwm_in));
  psfm_fault_manager psfm_fault_manager_inst (.clk(clk), .nrst(nrst), .pwm_in(pwm_in),
    .sense(sense), .hs_gate(hs_gate), .ls_gate(ls_gate), .pwm_pull_down(pull_down),
    .temp_fault_out(tf), .current_report_out(rep));
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  // fault flag only once the event limit is reached
  function automatic logic [6:0] oc_expect(input int events);
    return (events >= FAULT_EVENT_LIMIT) ? {TF_HIGH, REP_SENSE} : {TF_TEMP, REP_SENSE};
  endfunction : oc_expect
  task automatic chk(input string what, input logic [6:0] seen, input logic [6:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  // hold a sense pattern for n switching cycles, leave time for the latency
  task automatic drive(input logic [5:0] s, input int n);
    @(posedge clk);
    sense <= s;
    repeat (n) @(posedge pwm_in);
    repeat (4) @(negedge clk);
  endtask : drive
  // reset with a random switching period, then start up
  task automatic restart();
    lfsr = lfsr_next(lfsr);
    @(posedge clk);
    nrst <= 1'b0;
    sense <= '0;
    period <= 4'h3 + {1'b0, lfsr[2:0]};
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("lock", {tf, rep}, {TF_WEAK, REP_REF});
    chk("pull", {6'h00, pull_down}, 7'h01);
    drive(6'h03, 1);
    chk("run", {tf, rep}, {TF_TEMP, REP_SENSE});
    chk("pull", {6'h00, pull_down}, 7'h00);
  endtask : restart
  // main sequence
  initial begin
    restart();
    drive(6'h23, 5 + lfsr[1:0]);
    drive(6'h03, 4);
    drive(6'h23, 8);
    chk("oc", {tf, rep}, oc_expect(8));
    drive(6'h23, 12);
    drive(6'h03, 1);
    chk("oc", {tf, rep}, oc_expect(12));
    restart();
    drive(6'h13, 12);
    drive(6'h03, 2);
    chk("boot", {tf, rep}, {TF_HIGH, REP_ZERO});
    restart();
    drive(6'h0B, 1);
    drive(6'h03, 2);
    chk("short", {tf, rep}, {TF_HIGH, REP_HIGH});
    restart();
    // over-current in mid-pulse must cut the on-time at the next edge
    @(posedge hs_gate);
    sense <= 6'h23;
    repeat (2) @(negedge clk);
    chk("cut", {5'h00, hs_gate, ls_gate}, 7'h00);
    drive(6'h05, 1);
    chk("otp", {tf, rep}, {TF_HIGH, REP_REF});
    drive(6'h01, 1);
    chk("otp", {tf, rep}, {TF_HIGH, REP_REF});
    drive(6'h03, 1);
    chk("otp", {tf, rep}, {TF_TEMP, REP_SENSE});
    drive(6'h00, 1);
    chk("drop", {tf, rep}, {TF_WEAK, REP_ZERO});
    chk("pull", {6'h00, pull_down}, 7'h01);
    final_report();
  end
  // cycle ceiling against a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end
endmodule : psfm_fault_manager_tb
`default_nettype wire
